/* design/pslc_params.svh */
// Constants for the strap, reset and indicator block
`ifndef PSLC_PARAMS_SVH
`define PSLC_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define PSLC_CLK_MHZ 50
`define PSLC_RST_MIN_NS 1000
`define PSLC_RST_MIN_CYC ((`PSLC_RST_MIN_NS * `PSLC_CLK_MHZ + 999) / 1000)
`define PSLC_BLINK_MS 50
`define PSLC_BLINK_CYC (`PSLC_BLINK_MS * `PSLC_CLK_MHZ * 1000)

// ----------------------------------------
// Strap defaults (internal pulls)
// ----------------------------------------
`define PSLC_ADDR_RST 5'h01
`define PSLC_ADVERT_RST 2'h3

// ----------------------------------------
// Advertisement encodings, bit 3..0 = 100FD,100HD,10FD,10HD
// ----------------------------------------
`define PSLC_ADV_00 4'h3
`define PSLC_ADV_01 4'hC
`define PSLC_ADV_10 4'h5
`define PSLC_ADV_11 4'hF
`define PSLC_ADV_10HD_POS 0
`define PSLC_ADV_10FD_POS 1
`define PSLC_ADV_100HD_POS 2
`define PSLC_ADV_100FD_POS 3

`endif

/* design/pslc_pkg.sv */
// Types shared by the strap, reset and indicator block
`default_nettype none
package pslc_pkg;
  // ----------------------------------------
  // Latched configuration
  // ----------------------------------------
  typedef struct packed {
    logic [4:0] station_addr;
    logic isolate;
    logic [3:0] advert;
    logic [1:0] advert_strap;
  } pslc_cfg_s;

  // ----------------------------------------
  // Pins shared between strap and normal use
  // ----------------------------------------
  typedef struct packed {
    logic col;
    logic [3:0] rxd;
    logic link;
    logic speed;
  } pslc_pins_s;

  typedef enum logic [1:0] {
    PSLC_RESET = 2'b00,
    PSLC_SAMPLE = 2'b01,
    PSLC_RUN = 2'b11
  } pslc_state_e;
endpackage
`default_nettype wire

/* design/pslc_sync.sv */
// Three-stage synchroniser with agreement-based change detection
`default_nettype none
module pslc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
  logic [WIDTH-1:0] out_next;

  // First stage feeds only the second
  always_comb begin
    out_next = out_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        out_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      out_reg <= INIT;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;
endmodule
`default_nettype wire

/* design/pslc_top.sv */
// Hardware reset, strap capture and indicator driver
`include "pslc_params.svh"
`default_nettype none

module pslc_top #(
  parameter int BLINK_CYC = `PSLC_BLINK_CYC,
  parameter int RST_MIN_CYC = `PSLC_RST_MIN_CYC
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic hw_reset_n,
  input wire logic link_mode2,
  input wire logic link_good,
  input wire logic speed_100,
  input wire logic activity,
  input wire logic mii_col,
  input wire logic [3:0] mii_rxd,
  input wire logic [4:0] station_addr_strap,
  input wire logic advert_strap_lo,
  input wire logic advert_strap_hi,
  input wire logic addr_write,
  input wire logic [4:0] addr_write_data,
  output pslc_pkg::pslc_pins_s pins_out,
  output pslc_pkg::pslc_pins_s pins_oe,
  output pslc_pkg::pslc_cfg_s phy_control_reg,
  output logic in_reset,
  output logic link_indicator_out,
  output logic speed_indicator_out
);
  import pslc_pkg::*;

  // Counters below cannot serve a blink period under two cycles
  if (BLINK_CYC < 2 || RST_MIN_CYC < 1) begin : g_bad_counts
    $error("pslc_top: counts too small");
  end

  // ----------------------------------------
  // Reset pin capture
  // ----------------------------------------
  logic rst_n_sync;
  logic [6:0] straps_sync;

  // Starts low so power-up also waits until the strap levels have crossed the synchroniser
  pslc_sync #(.WIDTH(1), .INIT(1'b0)) u_rst_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in(hw_reset_n),
    .sync_out(rst_n_sync)
  );

  // Pulls give address 1 and advertisement 11 when no resistor fitted
  pslc_sync #(.WIDTH(7), .INIT({`PSLC_ADVERT_RST, `PSLC_ADDR_RST})) u_strap_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in({advert_strap_hi, advert_strap_lo, station_addr_strap}),
    .sync_out(straps_sync)
  );

  // ----------------------------------------
  // Reset sequencer
  // ----------------------------------------
  // Pulses shorter than the minimum are filtered so glitches do not wipe state
  pslc_state_e state_reg, state_next;
  logic [31:0] low_cnt_reg, low_cnt_next;

  always_comb begin
    state_next = state_reg;
    low_cnt_next = low_cnt_reg;
    case (state_reg)
      PSLC_RUN: begin
        if (!rst_n_sync) begin
          low_cnt_next = low_cnt_reg + 32'h0000_0001;
          if (low_cnt_reg + 32'h0000_0001 >= 32'(RST_MIN_CYC)) begin
            state_next = PSLC_RESET;
          end
        end else begin
          low_cnt_next = '0;
        end
      end
      PSLC_RESET: begin
        if (rst_n_sync) begin
          state_next = PSLC_SAMPLE;
        end
      end
      PSLC_SAMPLE: begin
        state_next = PSLC_RUN;
        low_cnt_next = '0;
      end
      default: begin
        state_next = PSLC_RESET;
        low_cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= PSLC_RESET;
      low_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      low_cnt_reg <= low_cnt_next;
    end
  end

  assign in_reset = (state_reg != PSLC_RUN);

  // ----------------------------------------
  // Configuration latch
  // ----------------------------------------
  pslc_cfg_s cfg_reg, cfg_next;

  function automatic logic [3:0] advert_map(input logic [1:0] s);
    case (s)
      2'b00: advert_map = `PSLC_ADV_00;
      2'b01: advert_map = `PSLC_ADV_01;
      2'b10: advert_map = `PSLC_ADV_10;
      default: advert_map = `PSLC_ADV_11;
    endcase
  endfunction

  always_comb begin
    cfg_next = cfg_reg;
    if (state_reg == PSLC_RESET) begin
      // Track straps while reset holds; the last value before release is kept
      cfg_next.station_addr = straps_sync[4:0];
      cfg_next.isolate = (straps_sync[4:0] == 5'h00);
      cfg_next.advert_strap = straps_sync[6:5];
      cfg_next.advert = advert_map(straps_sync[6:5]);
    end else if (state_reg == PSLC_RUN && addr_write) begin
      // Address zero written here never sets isolate
      cfg_next.station_addr = addr_write_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_reg <= '{station_addr: `PSLC_ADDR_RST, isolate: 1'b0,
                   advert: `PSLC_ADV_11, advert_strap: `PSLC_ADVERT_RST};
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign phy_control_reg = cfg_reg;

  // ----------------------------------------
  // Indicators
  // ----------------------------------------
  logic [31:0] blink_cnt_reg, blink_cnt_next;
  logic blink_reg, blink_next;
  logic link_led_reg, link_led_next;
  logic speed_led_reg, speed_led_next;

  always_comb begin
    blink_cnt_next = blink_cnt_reg;
    blink_next = blink_reg;
    if (!activity) begin
      blink_cnt_next = '0;
      blink_next = 1'b1;
    end else if (blink_cnt_reg >= 32'(BLINK_CYC - 1)) begin
      blink_cnt_next = '0;
      blink_next = !blink_reg;
    end else begin
      blink_cnt_next = blink_cnt_reg + 32'h0000_0001;
    end
    if (link_mode2) begin
      link_led_next = link_good && (blink_reg || !activity);
    end else begin
      link_led_next = link_good;
    end
    speed_led_next = speed_100;
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || in_reset) begin
      blink_cnt_reg <= '0;
      blink_reg <= 1'b1;
      link_led_reg <= 1'b0;
      speed_led_reg <= 1'b0;
    end else begin
      blink_cnt_reg <= blink_cnt_next;
      blink_reg <= blink_next;
      link_led_reg <= link_led_next;
      speed_led_reg <= speed_led_next;
    end
  end

  assign link_indicator_out = link_led_reg;
  assign speed_indicator_out = speed_led_reg;

  // ----------------------------------------
  // Shared pin drive
  // ----------------------------------------
  // Pins float during reset so the strap resistors set the level
  always_comb begin
    pins_out.col = mii_col;
    pins_out.rxd = mii_rxd;
    pins_out.link = link_led_reg;
    pins_out.speed = speed_led_reg;
    pins_oe = in_reset ? '0 : '1;
  end
endmodule
`default_nettype wire

/* testbench/pslc_asserts.sv */
// Checker for the strap, reset and indicator block
`include "pslc_params.svh"
`default_nettype none
module pslc_asserts #(
  parameter int BLINK_CYC = 4
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic link_mode2,
  input wire logic link_good,
  input wire logic speed_100,
  input wire logic activity,
  input wire logic addr_write,
  input wire logic [4:0] addr_write_data,
  input wire pslc_pkg::pslc_pins_s pins_oe,
  input wire pslc_pkg::pslc_cfg_s phy_control_reg,
  input wire logic in_reset,
  input wire logic link_indicator_out,
  input wire logic speed_indicator_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import pslc_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ----
  // Cycles the link indicator stays put while it should blink
  // ----
  logic [31:0] still_reg, still_next;
  logic led_reg, led_next;
  always_comb begin
    led_next = link_indicator_out;
    still_next = (!in_reset && link_mode2 && link_good && activity && link_indicator_out == led_reg) ?
      still_reg + 32'h0000_0001 : 32'h0000_0000;
  end
  always_ff @(posedge sys_clk) begin
    led_reg <= sys_rst ? 1'b0 : led_next;
    still_reg <= sys_rst ? 32'h0000_0000 : still_next;
  end
  // ----
  // Properties
  // ----
  sequence s_settled;
    !in_reset && !$past(in_reset);
  endsequence
  property p_oe; pins_oe == {7{!in_reset}}; endproperty
  a_oe: assert property (p_oe) else $error("pin enables disagree with reset state");
  property p_quiet; in_reset && $past(in_reset) |-> !link_indicator_out && !speed_indicator_out; endproperty
  a_quiet: assert property (p_quiet) else $error("indicator lit during reset");
  property p_speed; s_settled |-> speed_indicator_out == $past(speed_100); endproperty
  a_speed: assert property (p_speed) else $error("speed indicator wrong");
  property p_link; s_settled ##0 (!$past(link_mode2) || !$past(activity)) |-> link_indicator_out == $past(link_good);
  endproperty
  a_link: assert property (p_link) else $error("link indicator wrong");
  property p_blink; still_reg <= BLINK_CYC + 2; endproperty
  a_blink: assert property (p_blink) else $error("link indicator not blinking");
  property p_hold; s_settled ##0 !$past(addr_write) |-> $stable(phy_control_reg); endproperty
  a_hold: assert property (p_hold) else $error("configuration moved after release");
  property p_write; addr_write && !in_reset |=>
    phy_control_reg.station_addr == $past(addr_write_data) && $stable(phy_control_reg.isolate); endproperty
  a_write: assert property (p_write) else $error("address write wrong");
  property p_adv; phy_control_reg.advert == (phy_control_reg.advert_strap[1] ?
    (phy_control_reg.advert_strap[0] ? `PSLC_ADV_11 : `PSLC_ADV_10) :
    (phy_control_reg.advert_strap[0] ? `PSLC_ADV_01 : `PSLC_ADV_00)); endproperty
  a_adv: assert property (p_adv) else $error("advertisement does not match pattern");
  property p_dflt; disable iff (1'b0) sys_rst |=> in_reset && phy_control_reg == {5'h01, 1'b0, 4'hf, 2'h3};
  endproperty
  a_dflt: assert property (p_dflt) else $error("reset defaults wrong");
endmodule
bind pslc_top pslc_asserts #(.BLINK_CYC(BLINK_CYC)) u_chk (.sys_clk, .sys_rst, .link_mode2, .link_good,
  .speed_100, .activity, .addr_write, .addr_write_data, .pins_oe, .phy_control_reg, .in_reset,
  .link_indicator_out, .speed_indicator_out);
`default_nettype wire

/* testbench/pslc_board.sv */
// Board resistors and pulls on the shared strap pins
`default_nettype none
module pslc_board (
  input wire pslc_pkg::pslc_pins_s pins_out,
  input wire pslc_pkg::pslc_pins_s pins_oe,
  input wire logic [6:0] fit,
  input wire logic [6:0] fit_val,
  output logic [4:0] station_addr_strap,
  output logic advert_strap_lo,
  output logic advert_strap_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  import pslc_pkg::*;
  // Unfitted pins fall to the weak pulls: address one, pattern 11
  localparam logic [6:0] PULLS = 7'h43;
  logic [6:0] pin;
  // A driving device overrides the 2.2k straps
  assign pin = (pins_oe & pins_out) | (~pins_oe & ((fit & fit_val) | (~fit & PULLS)));
  assign {station_addr_strap[0], station_addr_strap[4:1], advert_strap_lo, advert_strap_hi} = pin;
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the strap, reset and indicator block
`include "pslc_params.svh"
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pslc_pkg::*;
  logic sys_clk = 0, sys_rst = 1, hw_reset_n = 1, link_mode2 = 0, link_good = 0, speed_100 = 0;
  logic activity = 0, mii_col = 0, addr_write = 0, advert_strap_lo, advert_strap_hi, in_reset, lp;
  logic link_indicator_out, speed_indicator_out;
  logic [3:0] mii_rxd = 4'h0;
  logic [4:0] addr_write_data = 5'h00, station_addr_strap;
  logic [6:0] fit = 7'h00, fit_val = 7'h00;
  logic [3:0] adv_tab [4] = '{`PSLC_ADV_00, `PSLC_ADV_01, `PSLC_ADV_10, `PSLC_ADV_11};
  pslc_pins_s pins_out, pins_oe;
  pslc_cfg_s phy_control_reg;
  int fail_count = 0, checks = 0, cyc = 0, n = 0;
  integer seed = 32'h0000_fdee;
  always #10 sys_clk = ~sys_clk;
  pslc_top #(.BLINK_CYC(4), .RST_MIN_CYC(2)) dut (.sys_clk, .sys_rst, .hw_reset_n, .link_mode2, .link_good,
    .speed_100, .activity, .mii_col, .mii_rxd, .station_addr_strap, .advert_strap_lo, .advert_strap_hi,
    .addr_write, .addr_write_data, .pins_out, .pins_oe, .phy_control_reg, .in_reset, .link_indicator_out,
    .speed_indicator_out);
  pslc_board u_board (.pins_out, .pins_oe, .fit, .fit_val, .station_addr_strap, .advert_strap_lo,
    .advert_strap_hi);
  // ----
  // Tasks
  // ----
  task automatic give_verdict();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hw_reset(input logic [4:0] a, input logic [1:0] adv);
    pslc_cfg_s exp;
    exp = '{a, a == 5'h00, adv_tab[adv], adv};
    fit_val = {a[0], a[4:1], adv[0], adv[1]};
    fit = 7'h7f;
    hw_reset_n = 0;
    // 1.2 microseconds (60 cycles of 20 ns) even though the design accepts far less
    repeat (60) @(negedge sys_clk);
    `CHK({in_reset, pins_oe}, 8'h80)
    hw_reset_n = 1;
    for (int i = 0; i < 20 && in_reset; i++) @(negedge sys_clk);
    `CHK({in_reset, pins_oe}, 8'h7f)
    `CHK(phy_control_reg, exp)
    $display("reset with address %0d pattern %0d done", a, adv);
  endtask
  // Mode 2 keeps activity low so the lit level is predictable
  task automatic leds(input logic m2);
    logic el, es;
    link_mode2 = m2;
    for (int i = 0; i < 60; i++) begin
      @(negedge sys_clk);
      if (i > 0) begin
        `CHK(link_indicator_out, el)
        `CHK(speed_indicator_out, es)
        `CHK(pins_out, {mii_col, mii_rxd, el, es})
      end
      {link_good, speed_100, mii_col, mii_rxd} = 7'($random(seed));
      activity = m2 ? 1'b0 : 1'($random(seed));
      el = link_good;
      es = speed_100;
    end
    $display("indicator mode %0d done", m2 + 1);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  // ----
  // Sequence
  // ----
  initial begin
    repeat (2) @(negedge sys_clk);
    sys_rst = 0;
    for (int i = 0; i < 20 && in_reset; i++) @(negedge sys_clk);
    `CHK(phy_control_reg, {5'h01, 1'b0, 4'hf, 2'h3})
    $display("default straps done");
    leds(0);
    leds(1);
    {link_good, activity, lp} = 3'h7;
    repeat (24) begin
      @(negedge sys_clk);
      n += (link_indicator_out !== lp);
      lp = link_indicator_out;
    end
    `CHK(n inside {[4:7]}, 1'b1)
    $display("blink done");
    for (int k = 0; k < 6; k++) begin
      hw_reset(k < 2 ? 5'(k * 31) : 5'($random(seed)), 2'(k));
      if (k == 1) begin
        {addr_write, addr_write_data} = 6'h20;
        @(negedge sys_clk);
        addr_write = 0;
        `CHK({phy_control_reg.station_addr, phy_control_reg.isolate}, 6'h00)
      end
    end
    give_verdict();
  end
endmodule
`default_nettype wire
